/* shared/acs_pkg.sv */
// acs_pkg: constants and types for the converter conversion sequencer
// assumes a single 250 MHz system clock and a 10-bit successive approximation core
package acs_pkg;

    localparam int unsigned RESULT_BITS  = 10;             // converted sample width
    localparam int unsigned TRIG_SEL_W   = 4;              // trigger_source_select width
    localparam int unsigned TRIG_COUNT   = 5;              // number of trigger sources

    // trigger_source_select encodings
    localparam logic [3:0] TRIG_NONE     = 4'h0;           // auto-trigger disabled
    localparam logic [3:0] TRIG_TIMER0   = 4'h1;           // timer0_wrap
    localparam logic [3:0] TRIG_TIMER1   = 4'h2;           // timer1_wrap
    localparam logic [3:0] TRIG_TIMER2   = 4'h3;           // timer2_period_hit
    localparam logic [3:0] TRIG_CELL1    = 4'h4;           // logic_cell1_output
    localparam logic [3:0] TRIG_CELL2    = 4'h5;           // logic_cell2_output

    // reset values
    localparam logic [9:0] RESULT_RESET  = 10'h000;        // result register reset value
    localparam logic [7:0] HIGH_RESET    = 8'h00;          // result_high reset value
    localparam logic [7:0] LOW_RESET     = 8'h00;          // result_low reset value

    // conversion bit time, one resolved bit per step
    localparam int unsigned BIT_TIME_NS  = 8;              // time per resolved bit
    localparam int unsigned CLK_PERIOD_NS = 4;             // system clock period
    localparam int unsigned BIT_CYCLES   = (BIT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0]  BIT_CYC_LAST = 4'(BIT_CYCLES - 1);

    // sequencer states
    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_CONVERT,
        ACS_PARKED
    } acs_state_t;

endpackage

/* core/acs_edge_detect.sv */
// acs_edge_detect: rising-edge detector for one trigger line
// assumes the input is synchronous to clk_i
module acs_edge_detect (
    input  wire logic clk_i,      // system clock
    input  wire logic reset_i,    // async reset, active high
    input  wire logic level_i,    // trigger level
    output logic      rise_o      // one-cycle pulse on a rising edge
);
    logic level_reg;              // previous sample

    // previous level register
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            level_reg <= 1'b0;
        end else begin
            level_reg <= level_i;
        end
    end

    assign rise_o = level_i & ~level_reg;
endmodule

/* core/acs_trigger_mux.sv */
// acs_trigger_mux: picks the selected auto-trigger source and flags its rising edge
// assumes trigger lines are synchronous to clk_i
module acs_trigger_mux
    import acs_pkg::*;
(
    input  wire logic                  clk_i,        // system clock
    input  wire logic                  reset_i,      // async reset, active high
    input  wire logic [TRIG_SEL_W-1:0] select_i,     // trigger_source_select
    input  wire logic [TRIG_COUNT-1:0] sources_i,    // raw trigger lines
    output logic                       trigger_o     // one-cycle pulse on selected rise
);
    logic [TRIG_COUNT-1:0] rise_w;                   // per-source rising edges

    // one detector per source
    for (genvar g = 0; g < TRIG_COUNT; g++) begin : g_edge
        acs_edge_detect u_edge (
            .clk_i   (clk_i),
            .reset_i (reset_i),
            .level_i (sources_i[g]),
            .rise_o  (rise_w[g])
        );
    end

    // source selection; unused codes give no trigger
    assign trigger_o = (select_i == TRIG_TIMER0) ? rise_w[0] :
                       (select_i == TRIG_TIMER1) ? rise_w[1] :
                       (select_i == TRIG_TIMER2) ? rise_w[2] :
                       (select_i == TRIG_CELL1)  ? rise_w[3] :
                       (select_i == TRIG_CELL2)  ? rise_w[4] : 1'b0;
endmodule

/* core/acs_sequencer.sv */
// acs_sequencer: conversion sequence control for the analog converter
// assumes software bits arrive as synchronous pulses and levels; the
// comparator decision of the analog core is sampled once per bit step
module acs_sequencer
    import acs_pkg::*;
(
    input  wire logic                  clk_i,                  // system clock
    input  wire logic                  reset_i,                // async reset, active high
    input  wire logic                  converter_on_i,         // converter_on bit
    input  wire logic                  go_set_i,               // software writes go = 1
    input  wire logic                  go_clear_i,             // software writes go = 0
    input  wire logic                  done_flag_clear_i,      // software clears done flag
    input  wire logic [TRIG_SEL_W-1:0] trigger_source_select_i, // auto-trigger select
    input  wire logic                  timer0_wrap_i,          // trigger source
    input  wire logic                  timer1_wrap_i,          // trigger source
    input  wire logic                  timer2_period_hit_i,    // trigger source
    input  wire logic                  logic_cell1_output_i,   // trigger source
    input  wire logic                  logic_cell2_output_i,   // trigger source
    input  wire logic                  sleep_i,                // device is in sleep
    input  wire logic                  dedicated_rc_clock_sel_i, // clock source is rc
    input  wire logic                  conversion_irq_enable_i,  // converter irq enable
    input  wire logic                  comparator_i,           // core decision for trial bit
    output logic                       conversion_go_o,        // go bit readback
    output logic                       conversion_done_flag_o, // done flag
    output logic [7:0]                 result_high_o,          // result bits 9:2
    output logic [7:0]                 result_low_o,           // result bits 1:0 at top
    output logic                       core_powered_o,         // analog core powered
    output logic                       sample_hold_o,          // core converting
    output logic [RESULT_BITS-1:0]     trial_code_o,           // code fed to core dac
    output logic                       wake_o                  // wake request pulse
);

    ////////////////////////////////////////////////////////////////////////////////
    // declarations

    acs_state_t             state_reg;     // sequencer state
    acs_state_t             state_next;    // next sequencer state
    logic [RESULT_BITS-1:0] sar_reg;       // successive approximation register
    logic [RESULT_BITS-1:0] sar_next;      // next sar value
    logic [3:0]             bit_idx_reg;   // bit under trial
    logic [3:0]             bit_idx_next;  // next bit index
    logic [3:0]             cyc_reg;       // cycles within a bit step
    logic [3:0]             cyc_next;      // next cycle count
    logic [RESULT_BITS-1:0] result_reg;    // held result
    logic [RESULT_BITS-1:0] result_next;   // next held result
    logic                   done_reg;      // conversion_done_flag
    logic                   done_next;     // next done flag
    logic                   wake_reg;      // wake pulse register
    logic                   wake_next;     // next wake pulse
    logic                   last_bit_reg;  // last converted bit value
    logic                   last_bit_next; // next last bit
    logic                   any_bit_reg;   // at least one bit resolved
    logic                   any_bit_next;  // next resolved marker

    logic                   auto_trig_w;   // selected trigger edge
    logic                   start_w;       // conversion start request
    logic                   step_end_w;    // bit step finishes this cycle
    logic                   final_bit_w;   // trial bit is bit 0
    logic                   resolved_w;    // value of bit being decided
    logic                   sleep_kill_w;  // sleep aborts on non-rc clock
    logic                   finish_w;      // normal completion this cycle
    logic                   abort_w;       // abort this cycle, by software or by sleep
    logic [RESULT_BITS-1:0] mask_w;        // ones below the trial bit
    logic [RESULT_BITS-1:0] partial_w;     // result for an abort
    logic [RESULT_BITS-1:0] final_w;       // result at completion
    logic [RESULT_BITS-1:0] trial_w;       // code under trial

    ////////////////////////////////////////////////////////////////////////////////
    // auto-trigger selection

    // edge detect and mux of the five sources
    acs_trigger_mux u_trig (
        .clk_i     (clk_i),
        .reset_i   (reset_i),
        .select_i  (trigger_source_select_i),
        .sources_i ({logic_cell2_output_i, logic_cell1_output_i, timer2_period_hit_i,
                     timer1_wrap_i, timer0_wrap_i}),
        .trigger_o (auto_trig_w)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // decode

    // start needs the converter on and not parked by sleep
    assign start_w      = converter_on_i & (state_reg == ACS_IDLE)
                          & (go_set_i | auto_trig_w);
    assign step_end_w   = (state_reg == ACS_CONVERT) && (cyc_reg == BIT_CYC_LAST);
    assign final_bit_w  = (bit_idx_reg == 4'h0);
    assign sleep_kill_w = sleep_i & ~dedicated_rc_clock_sel_i;
    // abort when software clears go, converter drops, or sleep on a foreign clock
    assign abort_w      = (state_reg == ACS_CONVERT)
                          & (go_clear_i | ~converter_on_i | sleep_kill_w);
    assign finish_w     = step_end_w & final_bit_w & ~abort_w;
    assign resolved_w   = comparator_i;
    assign trial_w      = sar_reg | (RESULT_BITS'(1) << bit_idx_reg);
    assign mask_w       = (RESULT_BITS'(1) << bit_idx_reg) - RESULT_BITS'(1);
    // unresolved bits, including the current trial bit, copy last converted bit
    assign partial_w    = last_bit_reg ? (sar_reg | mask_w | (RESULT_BITS'(1) << bit_idx_reg))
                                       : sar_reg;
    assign final_w      = sar_reg | (resolved_w ? RESULT_BITS'(1) : RESULT_BITS'(0));

    ////////////////////////////////////////////////////////////////////////////////
    // next-state logic

    // sequencer state machine
    always_comb begin
        state_next    = state_reg;
        sar_next      = sar_reg;
        bit_idx_next  = bit_idx_reg;
        cyc_next      = cyc_reg;
        result_next   = result_reg;
        done_next     = done_reg;
        wake_next     = 1'b0;
        last_bit_next = last_bit_reg;
        any_bit_next  = any_bit_reg;
        // software clear of the flag; a set below wins
        if (done_flag_clear_i) begin
            done_next = 1'b0;
        end
        case (state_reg)
            ACS_IDLE: begin
                if (start_w) begin
                    state_next    = ACS_CONVERT;
                    sar_next      = RESULT_RESET;
                    bit_idx_next  = 4'(RESULT_BITS - 1);
                    cyc_next      = 4'h0;
                    last_bit_next = 1'b0;
                    any_bit_next  = 1'b0;
                end
            end
            ACS_CONVERT: begin
                if (abort_w) begin
                    // partial result kept; sleep abort also parks the core
                    result_next = any_bit_reg ? partial_w : sar_reg;
                    state_next  = sleep_kill_w ? ACS_PARKED : ACS_IDLE;
                end else if (step_end_w) begin
                    cyc_next      = 4'h0;
                    last_bit_next = resolved_w;
                    any_bit_next  = 1'b1;
                    if (final_bit_w) begin
                        result_next = final_w;
                        done_next   = 1'b1;
                        if (sleep_i && conversion_irq_enable_i) begin
                            wake_next  = 1'b1;
                            state_next = ACS_IDLE;
                        end else if (sleep_i) begin
                            state_next = ACS_PARKED;
                        end else begin
                            state_next = ACS_IDLE;
                        end
                    end else begin
                        sar_next     = resolved_w ? trial_w : sar_reg;
                        bit_idx_next = bit_idx_reg - 4'h1;
                    end
                end else begin
                    cyc_next = cyc_reg + 4'h1;
                end
            end
            ACS_PARKED: begin
                // core stays off until sleep ends or converter_on drops
                if (!sleep_i || !converter_on_i) begin
                    state_next = ACS_IDLE;
                end
            end
            default: begin
                state_next = ACS_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    // state and datapath registers, all cleared by device reset
    always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_reg    <= ACS_IDLE;
            sar_reg      <= RESULT_RESET;
            bit_idx_reg  <= 4'h0;
            cyc_reg      <= 4'h0;
            result_reg   <= RESULT_RESET;
            done_reg     <= 1'b0;
            wake_reg     <= 1'b0;
            last_bit_reg <= 1'b0;
            any_bit_reg  <= 1'b0;
        end else begin
            state_reg    <= state_next;
            sar_reg      <= sar_next;
            bit_idx_reg  <= bit_idx_next;
            cyc_reg      <= cyc_next;
            result_reg   <= result_next;
            done_reg     <= done_next;
            wake_reg     <= wake_next;
            last_bit_reg <= last_bit_next;
            any_bit_reg  <= any_bit_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign conversion_go_o        = (state_reg == ACS_CONVERT);
    assign conversion_done_flag_o = done_reg;
    assign result_high_o          = result_reg[9:2];
    assign result_low_o           = {result_reg[1:0], 6'h00};
    // core powered only when on and not parked by sleep
    assign core_powered_o         = converter_on_i & (state_reg != ACS_PARKED);
    assign sample_hold_o          = (state_reg == ACS_CONVERT);
    assign trial_code_o           = trial_w;
    assign wake_o                 = wake_reg;

    ////////////////////////////////////////////////////////////////////////////////
    // assertions

    property p_go_needs_on;
        @(posedge clk_i) disable iff (reset_i)
        (state_reg == ACS_IDLE && !converter_on_i) |=> !conversion_go_o;
    endproperty
    a_go_needs_on: assert property (p_go_needs_on)
        else $error("conversion started with converter off");

    property p_done_on_finish;
        @(posedge clk_i) disable iff (reset_i)
        finish_w |=> (conversion_done_flag_o && !conversion_go_o);
    endproperty
    a_done_on_finish: assert property (p_done_on_finish)
        else $error("completion did not set done and clear go");

    // a software clear landing with the abort may still drop the flag
    property p_abort_stops;
        @(posedge clk_i) disable iff (reset_i)
        (abort_w && !done_flag_clear_i)
            |=> (!conversion_go_o && $stable(conversion_done_flag_o));
    endproperty
    a_abort_stops: assert property (p_abort_stops)
        else $error("abort left go set or touched done");

    property p_fill_bits;
        @(posedge clk_i) disable iff (reset_i)
        (abort_w && any_bit_reg && last_bit_reg) |=> (result_reg[0] == 1'b1);
    endproperty
    a_fill_bits: assert property (p_fill_bits)
        else $error("unresolved bits not filled with last bit");

    // eight undisturbed cycles of conversion must be followed by a ninth
    property p_conv_length;
        @(posedge clk_i) disable iff (reset_i)
        (start_w && !go_clear_i) ##1 (conversion_go_o && converter_on_i && !sleep_i
            && !go_clear_i)[*8] |=> conversion_go_o;
    endproperty
    a_conv_length: assert property (p_conv_length)
        else $error("conversion ended early");

    property p_sleep_kill;
        @(posedge clk_i) disable iff (reset_i)
        (conversion_go_o && sleep_kill_w) |=> (!conversion_go_o && !core_powered_o);
    endproperty
    a_sleep_kill: assert property (p_sleep_kill)
        else $error("foreign-clock sleep did not abort and power down");

    property p_wake;
        @(posedge clk_i) disable iff (reset_i)
        (finish_w && sleep_i && conversion_irq_enable_i) |=> wake_o ##1 !wake_o;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no single wake pulse on sleep completion");

    property p_park;
        @(posedge clk_i) disable iff (reset_i)
        (finish_w && sleep_i && !conversion_irq_enable_i && converter_on_i)
            |=> (!core_powered_o && !wake_o);
    endproperty
    a_park: assert property (p_park)
        else $error("core not powered down after sleep completion");

    property p_trigger;
        @(posedge clk_i) disable iff (reset_i)
        (auto_trig_w && converter_on_i && state_reg == ACS_IDLE) |=> conversion_go_o;
    endproperty
    a_trigger: assert property (p_trigger)
        else $error("trigger edge did not start conversion");

    c_finish: cover property (@(posedge clk_i) disable iff (reset_i) finish_w);
    c_abort:  cover property (@(posedge clk_i) disable iff (reset_i) abort_w && any_bit_reg);
    c_wake:   cover property (@(posedge clk_i) disable iff (reset_i) wake_o);
    c_trig:   cover property (@(posedge clk_i) disable iff (reset_i) auto_trig_w && start_w);

endmodule

/* dv/acs_core_model.sv */
// acs_core_model: behavioural analog core answering the sequencer trial codes
// assumes trial_code_i settles from registers shortly after each clk_i edge
module acs_core_model
    import acs_pkg::*;
(
    input  wire logic                   clk_i,        // system clock
    input  wire logic [RESULT_BITS-1:0] level_i,      // analog input as an ideal code
    input  wire logic [RESULT_BITS-1:0] trial_code_i, // dac code from the sequencer
    input  wire logic                   hold_i,       // sample held, converting
    input  wire logic                   powered_i,    // analog core powered
    output logic                        comparator_o  // keep-bit decision
);
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////////
    logic idle_pattern_reg = 1'b0;                    // toggles while no decision is due
    // idle toggle so a stray sample never looks settled
    always_ff @(posedge clk_i) begin
        idle_pattern_reg <= ~idle_pattern_reg;
    end
    // decision holds only while powered and holding a sample
    assign comparator_o = (hold_i && powered_i) ? (trial_code_i <= level_i) : idle_pattern_reg;
endmodule

/* dv/acs_sequencer_tb.sv */
// acs_sequencer_tb: self-checking bench for the conversion sequencer
// assumes acs_pkg timing: result and done land RESULT_BITS*BIT_CYCLES after go rises
module acs_sequencer_tb import acs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    ////////////////////////////////////////////////////////////////////////////////
    logic                  clk_i = 1'b0;                            // 250 MHz clock
    logic                  reset_i, converter_on_i, go_set_i, go_clear_i, done_clr;
    logic                  sleep_i, rc_sel, irq_en, comparator;     // sleep and core side
    logic [TRIG_SEL_W-1:0] sel;                                     // trigger select
    logic [4:0]            lines;                                   // trigger lines
    logic [9:0]            level, trial;                            // analog level, dac code
    logic                  go_o, done_o, powered_o, hold_o, wake_o; // observed outputs
    logic [7:0]            high_o, low_o;                           // result bytes
    int                    num_errors = 0;                          // mismatches
    int                    samples_checked = 0;                     // comparisons
    always #2 clk_i = ~clk_i;
    acs_sequencer DUT (.clk_i(clk_i), .reset_i(reset_i), .converter_on_i(converter_on_i),
        .go_set_i(go_set_i), .go_clear_i(go_clear_i), .done_flag_clear_i(done_clr),
        .trigger_source_select_i(sel), .timer0_wrap_i(lines[0]), .timer1_wrap_i(lines[1]),
        .timer2_period_hit_i(lines[2]), .logic_cell1_output_i(lines[3]),
        .logic_cell2_output_i(lines[4]), .sleep_i(sleep_i), .dedicated_rc_clock_sel_i(rc_sel),
        .conversion_irq_enable_i(irq_en), .comparator_i(comparator), .conversion_go_o(go_o),
        .conversion_done_flag_o(done_o), .result_high_o(high_o), .result_low_o(low_o),
        .core_powered_o(powered_o), .sample_hold_o(hold_o), .trial_code_o(trial),
        .wake_o(wake_o));
    acs_core_model core (.clk_i(clk_i), .level_i(level), .trial_code_i(trial),
        .hold_i(hold_o), .powered_i(powered_o), .comparator_o(comparator));
    ////////////////////////////////////////////////////////////////////////////////
    // compare and count
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // expected partial sample: unresolved bits copy the last resolved one
    function automatic logic [9:0] fill(input logic [9:0] v, input int n);
        logic [9:0] r;
        for (int i = 0; i < 10; i++) begin
            r[9-i] = (i < n) ? v[9-i] : ((n == 0) ? 1'b0 : v[10-n]);
        end
        return r;
    endfunction
    task automatic chk_result(input logic [9:0] v);
        chk("result_high", {8'h00, high_o}, {8'h00, v[9:2]});
        chk("result_low", {8'h00, low_o}, {8'h00, v[1:0], 6'h00});
    endtask
    // one-cycle pulse: go_set_i when go is set, done_clr otherwise
    task automatic pulse(input logic go);
        @(posedge clk_i);
        if (go) go_set_i <= 1'b1;
        else done_clr <= 1'b1;
        @(posedge clk_i) {go_set_i, done_clr} <= 2'b00;
        #1;
    endtask
    // count cycles while go reads one, bounded
    task automatic wait_done(output int n);
        n = 0;
        while (go_o === 1'b1 && n < 100) begin
            @(posedge clk_i);
            #1 n++;
        end
    endtask
    task automatic clear_done;
        pulse(1'b0);
        chk("done_cleared", {15'h0000, done_o}, 16'h0000);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // full conversions back to back, boundary codes included
    task automatic t_full;
        logic [9:0] vals [3] = '{10'h2A5, 10'h3FF, 10'h000};
        int n;
        foreach (vals[i]) begin
            level <= vals[i];
            clear_done();
            pulse(1'b1);
            chk("go_running", {15'h0000, go_o}, 16'h0001);
            chk("hold", {15'h0000, hold_o}, 16'h0001);
            chk("first_trial", {6'h00, trial}, 16'(1 << (RESULT_BITS - 1)));
            wait_done(n);
            chk("conv_cycles", 16'(n), 16'(RESULT_BITS * BIT_CYCLES));
            chk("done_set", {15'h0000, done_o}, 16'h0001);
            chk_result(vals[i]);
        end
    endtask
    // start refused while the converter is off; dropping it mid-run aborts
    task automatic t_off;
        pulse(1'b1);
        converter_on_i <= 1'b0;
        @(posedge clk_i);
        #1 chk("go_on_dropped", {15'h0000, go_o}, 16'h0000);
        pulse(1'b1);
        repeat (3) @(posedge clk_i);
        chk("go_while_off", {15'h0000, go_o}, 16'h0000);
        converter_on_i <= 1'b1; // enable well ahead of any go
        repeat (2) @(posedge clk_i);
    endtask
    // abort after three resolved bits, by software or by sleep off the rc clock
    task automatic t_abort(input logic by_sleep);
        level <= 10'h2A5;
        clear_done();
        pulse(1'b1);
        repeat (6) @(posedge clk_i);
        if (by_sleep) sleep_i <= 1'b1;
        else go_clear_i <= 1'b1;
        @(posedge clk_i) go_clear_i <= 1'b0;
        #1 chk("go_aborted", {15'h0000, go_o}, 16'h0000);
        chk_result(fill(10'h2A5, 3));
        chk("done_after_abort", {15'h0000, done_o}, 16'h0000);
        chk("powered", {15'h0000, powered_o}, {15'h0000, ~by_sleep});
        @(posedge clk_i) sleep_i <= 1'b0;
        @(posedge clk_i);
        #1 chk("powered_again", {15'h0000, powered_o}, 16'h0001);
    endtask
    // conversion through sleep on the rc clock, irq on and off
    task automatic t_sleep_rc(input logic irq);
        int n;
        level <= 10'h155;
        rc_sel <= 1'b1;
        irq_en <= irq; // stands for both irq enables set
        clear_done();
        pulse(1'b1);
        @(posedge clk_i) sleep_i <= 1'b1;
        wait_done(n);
        chk("sleep_result_done", {15'h0000, done_o}, 16'h0001);
        chk_result(10'h155);
        chk("wake", {15'h0000, wake_o}, {15'h0000, irq});
        chk("powered_sleep", {15'h0000, powered_o}, {15'h0000, irq});
        @(posedge clk_i) sleep_i <= 1'b0;
        rc_sel <= 1'b0;
        #1 chk("wake_pulse", {15'h0000, wake_o}, 16'h0000);
    endtask
    // reset in mid conversion with done still set
    task automatic t_reset;
        pulse(1'b1);
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b1;
        #1 chk("go_reset", {15'h0000, go_o}, 16'h0000);
        chk("done_reset", {15'h0000, done_o}, 16'h0000);
        chk_result(RESULT_RESET);
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
    endtask
    // select codes 0..6; only codes 1..5 start on their own line
    task automatic t_triggers;
        int n;
        for (int c = 0; c < 7; c++) begin
            logic exp;
            exp = (c >= 1 && c <= 5);
            clear_done();
            @(posedge clk_i) sel <= 4'(c);
            @(posedge clk_i) lines <= exp ? 5'(1 << (c - 1)) : 5'h1F;
            n = 0;
            while (go_o !== 1'b1 && n < 6) begin
                @(posedge clk_i);
                #1 n++;
            end
            chk("trigger_start", {15'h0000, go_o}, {15'h0000, exp});
            wait_done(n); // next trigger only after completion
            lines <= 5'h00;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict;
        $display("checked %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // watchdog, far beyond the few hundred cycles of the tests
    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        give_verdict();
    end
    // main sequence
    initial begin
        {reset_i, converter_on_i, go_set_i, go_clear_i, done_clr} = 5'h10;
        {sleep_i, rc_sel, irq_en, sel, lines, level} = '0;
        repeat (4) @(posedge clk_i);
        reset_i <= 1'b0;
        converter_on_i <= 1'b1; // enabled before the first go
        repeat (2) @(posedge clk_i);
        t_full();
        t_off();
        t_abort(1'b0);
        t_abort(1'b1);
        t_sleep_rc(1'b1);
        t_sleep_rc(1'b0);
        t_reset();
        t_triggers();
        give_verdict();
    end
endmodule
